// >>> design/spr_pkg.sv
// Package: register map, field positions and reset values
package spr_pkg;

    // ------------------------------------------------------------------
    // Register offsets
    // ------------------------------------------------------------------
    localparam int          ADDR_W           = 7;
    localparam logic [6:0]  ADDR_LOOP_PWR    = 7'h02;
    localparam logic [6:0]  ADDR_REFERENCE_CLOCK_OUT      = 7'h03;

    // ------------------------------------------------------------------
    // Loop power and reference select fields
    // ------------------------------------------------------------------
    localparam int          LP_PWR_OVR       = 0;
    localparam int          LP_A_ON          = 1;
    localparam int          LP_B_GATE        = 2;
    localparam int          LP_B_ON          = 3;
    localparam int          LP_REF_OVR       = 4;
    localparam int          LP_REF_CHOICE    = 5;
    localparam logic [15:0] LOOP_PWR_RST     = 16'h0000;
    localparam logic [15:0] LOOP_PWR_WMASK   = 16'h003F;

    // ------------------------------------------------------------------
    // Reference output and divider enable fields
    // ------------------------------------------------------------------
    localparam int          RO_MODE_LSB      = 30;
    localparam int          RO_ACT_DET       = 28;
    localparam int          RO_SRC_SEL       = 27;
    localparam int          RO_XTAL_KEEP     = 26;
    localparam int          RO_DIV_LSB       = 16;
    localparam logic [31:0] REFERENCE_CLOCK_OUT_RST       = 32'h1000_0000;
    localparam logic [31:0] REFERENCE_CLOCK_OUT_WMASK     = 32'hDC0F_0000;

    // ------------------------------------------------------------------
    // Serial frame layout
    // ------------------------------------------------------------------
    localparam int          CMD_BITS         = 8;
    localparam int          DATA_BITS        = 32;
    localparam logic [5:0]  CMD_LAST         = 6'h07;
    localparam logic [5:0]  DATA_LAST        = 6'h1F;

    typedef enum logic [1:0] {
        SPR_IDLE,
        SPR_CMD,
        SPR_DATA,
        SPR_DONE
    } spr_state_t;

endpackage

// >>> design/spr_reg_if.sv
// Interface: register access between serial slave and register file
`timescale 1ns/1ps
`default_nettype none
interface spr_reg_if;
    logic        wr_stb;
    logic [6:0]  addr;
    logic [31:0] wdata;
    logic [31:0] rdata;

    modport slave (
        output wr_stb,
        output addr,
        output wdata,
        input  rdata
    );

    modport regs (
        input  wr_stb,
        input  addr,
        input  wdata,
        output rdata
    );
endinterface
`default_nettype wire

// >>> design/spr_spi_slave.sv
// Serial slave: frame shifter feeding the register interface
`timescale 1ns/1ps
`default_nettype none
module spr_spi_slave #(
    parameter int ADDR_BITS = 7
) (
    // Clock and reset
    input  wire logic clock,
    input  wire logic sys_rst,
    // Serial pins
    input  wire logic spi_cs_n,
    input  wire logic spi_sclk,
    input  wire logic spi_sdi,
    output var  logic spi_sdo,
    output var  logic spi_sdo_oe,
    // Register side
    spr_reg_if.slave  bus
);
    if (ADDR_BITS != spr_pkg::ADDR_W) begin : g_chk
        $error("spr_spi_slave: ADDR_BITS must equal 7");
    end

    spr_pkg::spr_state_t state_r, state_nxt;
    logic        sclk_q_r, sclk_q_nxt;
    logic [5:0]  cnt_r, cnt_nxt;
    logic [31:0] in_r, in_nxt;
    logic [31:0] out_r, out_nxt;
    logic        rd_r, rd_nxt;
    logic        load_r, load_nxt;
    logic [6:0]  addr_r, addr_nxt;
    logic [31:0] wdata_r, wdata_nxt;
    logic        wr_r, wr_nxt;
    logic        sdo_r, sdo_nxt;
    logic        oe_r, oe_nxt;
    logic        rise;
    logic        fall;

    // ------------------------------------------------------------------
    // Frame sequencing
    // ------------------------------------------------------------------
    always_comb begin
        rise       = spi_sclk & ~sclk_q_r;
        fall       = ~spi_sclk & sclk_q_r;
        state_nxt  = state_r;
        sclk_q_nxt = spi_sclk;
        cnt_nxt    = cnt_r;
        in_nxt     = in_r;
        out_nxt    = out_r;
        rd_nxt     = rd_r;
        load_nxt   = 1'b0;
        addr_nxt   = addr_r;
        wdata_nxt  = wdata_r;
        wr_nxt     = 1'b0;
        sdo_nxt    = sdo_r;
        oe_nxt     = oe_r;
        if (spi_cs_n) begin
            state_nxt = spr_pkg::SPR_IDLE;
            cnt_nxt   = 6'h00;
            oe_nxt    = 1'b0;
        end else begin
            case (state_r)
                spr_pkg::SPR_IDLE, spr_pkg::SPR_CMD: begin
                    state_nxt = spr_pkg::SPR_CMD;
                    if (rise) begin
                        in_nxt  = {in_r[30:0], spi_sdi};
                        cnt_nxt = cnt_r + 6'h01;
                        if (cnt_r == spr_pkg::CMD_LAST) begin
                            rd_nxt    = in_r[6];
                            addr_nxt  = {in_r[5:0], spi_sdi};
                            cnt_nxt   = 6'h00;
                            load_nxt  = 1'b1;
                            state_nxt = spr_pkg::SPR_DATA;
                        end
                    end
                end
                spr_pkg::SPR_DATA: begin
                    if (load_r) begin
                        out_nxt = bus.rdata;
                        sdo_nxt = bus.rdata[31];
                        oe_nxt  = rd_r;
                    end else if (fall && cnt_r != 6'h00) begin
                        out_nxt = {out_r[30:0], 1'b0};
                        sdo_nxt = out_r[30];
                    end
                    if (rise) begin
                        in_nxt  = {in_r[30:0], spi_sdi};
                        cnt_nxt = cnt_r + 6'h01;
                        if (cnt_r == spr_pkg::DATA_LAST) begin
                            wr_nxt    = ~rd_r;
                            wdata_nxt = {in_r[30:0], spi_sdi};
                            state_nxt = spr_pkg::SPR_DONE;
                        end
                    end
                end
                default: begin
                    state_nxt = spr_pkg::SPR_DONE;
                end
            endcase
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            state_r  <= spr_pkg::SPR_IDLE;
            sclk_q_r <= 1'b0;
            cnt_r    <= 6'h00;
            in_r     <= 32'h0000_0000;
            out_r    <= 32'h0000_0000;
            rd_r     <= 1'b0;
            load_r   <= 1'b0;
            addr_r   <= 7'h00;
            wdata_r  <= 32'h0000_0000;
            wr_r     <= 1'b0;
            sdo_r    <= 1'b0;
            oe_r     <= 1'b0;
        end else begin
            state_r  <= state_nxt;
            sclk_q_r <= sclk_q_nxt;
            cnt_r    <= cnt_nxt;
            in_r     <= in_nxt;
            out_r    <= out_nxt;
            rd_r     <= rd_nxt;
            load_r   <= load_nxt;
            addr_r   <= addr_nxt;
            wdata_r  <= wdata_nxt;
            wr_r     <= wr_nxt;
            sdo_r    <= sdo_nxt;
            oe_r     <= oe_nxt;
        end
    end

    assign bus.wr_stb = wr_r;
    assign bus.addr   = addr_r;
    assign bus.wdata  = wdata_r;
    assign spi_sdo    = sdo_r;
    assign spi_sdo_oe = oe_r;

endmodule // spr_spi_slave
`default_nettype wire

// >>> design/spr_top.sv
// Top: loop power, reference select and reference output registers
//
// Summary of operation
// - Loop A uses reference 1 unless override bit 4 and choice bit 5 are both set.
// - With override set, choice bit 1 picks reference 2, 0 reference 1.
// - Loop B on/off bit 3 acts only while gate bit 2 is one.
// - Gate bit 2 at zero holds loop B powered down regardless of bit 3.
// - Power override bit 0 gives loop A power to bit 1, else the pin.
// - With override set, bit 1 written one enables loop A, zero disables.
// - With override clear, bit 1 is read-only and reads the pin level.
// - Bits 31:30 pick reference output mode: CMOS, LVDS, LVPECL, HCSL.
// - Bit 28 enables activity detectors, resets to one, host keeps it one.
// - Bit 27 picks reference output source: one reference 2, zero ref 1.
// - Bit 26 keeps crystal A oscillator running; host normally leaves zero.
// - Crystal A runs whenever reference 1 is selected, keep-alive or not.
// - Bits 19, 18, 17 enable dividers for outputs four, three, two.
// - Bit 16 enables the divider for output one.
`timescale 1ns/1ps
`default_nettype none
module spr_top (
    // Clock and reset
    input  wire logic       clock,
    input  wire logic       sys_rst,
    // Serial host port
    input  wire logic       spi_cs_n,
    input  wire logic       spi_sclk,
    input  wire logic       spi_sdi,
    output var  logic       spi_sdo,
    output var  logic       spi_sdo_oe,
    // Loop power pin
    input  wire logic       loop_a_powerdown_pin,
    // Loop controls
    output var  logic       loop_a_on,
    output var  logic       loop_b_on,
    output var  logic       loop_a_ref_choice,
    // Reference output controls
    output var  logic [1:0] reference_out_mode,
    output var  logic       activity_detect_en,
    output var  logic       reference_out_src,
    output var  logic       crystal_a_enable,
    // Output divider enables, index 0 is output one
    output var  logic [3:0] divider_en
);

    spr_reg_if bus ();

    // ------------------------------------------------------------------
    // Elaboration checks
    // ------------------------------------------------------------------
    if (spr_pkg::RO_MODE_LSB + 2 > 32) begin : g_chk_mode
        $error("spr_top: driver mode field outside the register");
    end
    if (spr_pkg::RO_DIV_LSB + 4 > 32) begin : g_chk_div
        $error("spr_top: divider field outside the register");
    end
    if (spr_pkg::LP_REF_CHOICE > 15) begin : g_chk_loop
        $error("spr_top: loop field outside the register");
    end

    // ------------------------------------------------------------------
    // Address decode
    // ------------------------------------------------------------------
    function automatic logic hits_loop(input logic [6:0] addr);
        return addr == spr_pkg::ADDR_LOOP_PWR;
    endfunction

    function automatic logic hits_reference_clock_out(input logic [6:0] addr);
        return addr == spr_pkg::ADDR_REFERENCE_CLOCK_OUT;
    endfunction

    // ------------------------------------------------------------------
    // Serial slave
    // ------------------------------------------------------------------
    spr_spi_slave #(
        .ADDR_BITS (spr_pkg::ADDR_W)
    ) u_spi (
        .clock      (clock),
        .sys_rst    (sys_rst),
        .spi_cs_n   (spi_cs_n),
        .spi_sclk   (spi_sclk),
        .spi_sdi    (spi_sdi),
        .spi_sdo    (spi_sdo),
        .spi_sdo_oe (spi_sdo_oe),
        .bus        (bus.slave)
    );

    // ------------------------------------------------------------------
    // Register storage
    // ------------------------------------------------------------------
    logic [15:0] lp_r, lp_nxt;
    logic [31:0] ro_r, ro_nxt;

    always_comb begin
        lp_nxt = lp_r;
        ro_nxt = ro_r;
        if (bus.wr_stb) begin
            if (hits_loop(bus.addr)) begin
                lp_nxt = bus.wdata[15:0] & spr_pkg::LOOP_PWR_WMASK;
            end else if (hits_reference_clock_out(bus.addr)) begin
                ro_nxt = bus.wdata & spr_pkg::REFERENCE_CLOCK_OUT_WMASK;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            lp_r <= spr_pkg::LOOP_PWR_RST;
            ro_r <= spr_pkg::REFERENCE_CLOCK_OUT_RST;
        end else begin
            lp_r <= lp_nxt;
            ro_r <= ro_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Readback
    // ------------------------------------------------------------------
    function automatic logic [31:0] rd_word(
        input logic [6:0]  addr,
        input logic [15:0] lp,
        input logic [31:0] ro,
        input logic        pin
    );
        logic [31:0] w;
        w = 32'h0000_0000;
        if (hits_loop(addr)) begin
            w[15:0] = lp;
            if (!lp[spr_pkg::LP_PWR_OVR]) begin
                w[spr_pkg::LP_A_ON] = pin;
            end
        end else if (hits_reference_clock_out(addr)) begin
            w = ro;
        end
        return w;
    endfunction

    assign bus.rdata = rd_word(bus.addr, lp_r, ro_r, loop_a_powerdown_pin);

    // ------------------------------------------------------------------
    // Loop controls
    // ------------------------------------------------------------------
    logic       a_on_r, a_on_nxt;
    logic       b_on_r, b_on_nxt;
    logic       ref_r, ref_nxt;

    always_comb begin
        if (lp_r[spr_pkg::LP_PWR_OVR]) begin
            a_on_nxt = lp_r[spr_pkg::LP_A_ON];
        end else begin
            a_on_nxt = loop_a_powerdown_pin;
        end
        b_on_nxt = lp_r[spr_pkg::LP_B_GATE]
                 & lp_r[spr_pkg::LP_B_ON];
        ref_nxt  = lp_r[spr_pkg::LP_REF_OVR]
                 & lp_r[spr_pkg::LP_REF_CHOICE];
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            a_on_r <= 1'b0;
            b_on_r <= 1'b0;
            ref_r  <= 1'b0;
        end else begin
            a_on_r <= a_on_nxt;
            b_on_r <= b_on_nxt;
            ref_r  <= ref_nxt;
        end
    end

    // ------------------------------------------------------------------
    // Reference output controls
    // ------------------------------------------------------------------
    logic [1:0] mode_r, mode_nxt;
    logic       act_r, act_nxt;
    logic       src_r, src_nxt;
    logic       xtal_r, xtal_nxt;
    logic [3:0] div_r, div_nxt;
    logic       need_loop_a;
    logic       need_reference_clock_out;

    always_comb begin
        mode_nxt    = ro_r[spr_pkg::RO_MODE_LSB +: 2];
        act_nxt     = ro_r[spr_pkg::RO_ACT_DET];
        src_nxt     = ro_r[spr_pkg::RO_SRC_SEL];
        need_loop_a = ~ref_nxt;
        need_reference_clock_out = ~src_nxt;
        xtal_nxt    = ro_r[spr_pkg::RO_XTAL_KEEP]
                    | need_loop_a
                    | need_reference_clock_out;
        div_nxt     = ro_r[spr_pkg::RO_DIV_LSB +: 4];
    end

    always_ff @(posedge clock) begin
        if (sys_rst) begin
            mode_r <= spr_pkg::REFERENCE_CLOCK_OUT_RST[spr_pkg::RO_MODE_LSB +: 2];
            act_r  <= spr_pkg::REFERENCE_CLOCK_OUT_RST[spr_pkg::RO_ACT_DET];
            src_r  <= spr_pkg::REFERENCE_CLOCK_OUT_RST[spr_pkg::RO_SRC_SEL];
            xtal_r <= 1'b1;
            div_r  <= spr_pkg::REFERENCE_CLOCK_OUT_RST[spr_pkg::RO_DIV_LSB +: 4];
        end else begin
            mode_r <= mode_nxt;
            act_r  <= act_nxt;
            src_r  <= src_nxt;
            xtal_r <= xtal_nxt;
            div_r  <= div_nxt;
        end
    end

    assign loop_a_on          = a_on_r;
    assign loop_b_on          = b_on_r;
    assign loop_a_ref_choice  = ref_r;
    assign reference_out_mode = mode_r;
    assign activity_detect_en = act_r;
    assign reference_out_src  = src_r;
    assign crystal_a_enable   = xtal_r;
    assign divider_en         = div_r;

endmodule // spr_top
`default_nettype wire

// >>> bench/spr_top_properties.sv
// Checker: port-level properties of the register block
`timescale 1ns/1ps
`default_nettype none
module spr_checker (
    // Clock and reset
    input wire logic       clock,
    input wire logic       sys_rst,
    // Serial pins
    input wire logic       spi_cs_n,
    input wire logic       spi_sclk,
    input wire logic       spi_sdo,
    input wire logic       spi_sdo_oe,
    // Loop controls
    input wire logic       loop_a_powerdown_pin,
    input wire logic       loop_a_on,
    input wire logic       loop_b_on,
    input wire logic       loop_a_ref_choice,
    // Reference output controls
    input wire logic [1:0] reference_out_mode,
    input wire logic       reference_out_src,
    input wire logic       crystal_a_enable,
    input wire logic [3:0] divider_en
);
    default clocking cb @(posedge clock);
    endclocking
    default disable iff (sys_rst);

    sequence quiet_s;
        spi_cs_n [*5];
    endsequence
    sequence sclk_high_s;
        spi_sclk [*6];
    endsequence
    sequence pin_steady_s;
        $stable(loop_a_powerdown_pin) [*6];
    endsequence

    a_crystal_ref_one: assert property (
        !reference_out_src |-> crystal_a_enable)
        else $error("crystal off while reference output uses it");
    a_oe_idle_low: assert property (spi_cs_n [*3] |-> !spi_sdo_oe)
        else $error("data out driven outside a frame");
    a_oe_rise_frame: assert property (
        $rose(spi_sdo_oe) |-> !spi_cs_n && !$past(spi_cs_n))
        else $error("data out enabled without a frame");
    a_sdo_holds: assert property (sclk_high_s |-> $stable(spi_sdo))
        else $error("data out moved while serial clock high");
    a_mode_quiet: assert property (
        quiet_s |-> $stable(reference_out_mode))
        else $error("driver mode changed without access");
    a_src_quiet: assert property (
        quiet_s |-> $stable(reference_out_src))
        else $error("reference source changed without access");
    a_div_quiet: assert property (
        quiet_s |-> $stable(divider_en))
        else $error("divider enables changed without access");
    a_loopb_quiet: assert property (
        quiet_s |-> $stable(loop_b_on))
        else $error("loop b power changed without access");
    a_choice_quiet: assert property (
        quiet_s |-> $stable(loop_a_ref_choice))
        else $error("loop a reference changed without access");
    a_loopa_quiet: assert property (
        quiet_s and pin_steady_s |-> $stable(loop_a_on))
        else $error("loop a power changed with pin steady");
endmodule // spr_checker

bind spr_top spr_checker u_spr_checker (
    .clock(clock), .sys_rst(sys_rst), .spi_cs_n(spi_cs_n),
    .spi_sclk(spi_sclk), .spi_sdo(spi_sdo), .spi_sdo_oe(spi_sdo_oe),
    .loop_a_powerdown_pin(loop_a_powerdown_pin), .loop_a_on(loop_a_on),
    .loop_b_on(loop_b_on), .loop_a_ref_choice(loop_a_ref_choice),
    .reference_out_mode(reference_out_mode),
    .reference_out_src(reference_out_src),
    .crystal_a_enable(crystal_a_enable), .divider_en(divider_en)
);
`default_nettype wire

// >>> bench/spr_top_tb_top.sv
// Testbench: serial register accesses with expected values
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_fail++; \
    $display("mismatch %s exp %0h seen %0h", nm, e, g); end end
module spr_top_tb_top;
    logic       clock, sys_rst, spi_cs_n, spi_sclk, spi_sdi, pin;
    logic       spi_sdo, spi_sdo_oe, loop_a_on, loop_b_on, ref_choice;
    logic       act_en, ro_src, xtal_en;
    logic [1:0] ro_mode;
    logic [3:0] div_en;
    logic [31:0] q;
    logic        oe_q;
    int         tests_run = 0;
    int         n_fail = 0;

    spr_top u_spr_top (
        .clock(clock), .sys_rst(sys_rst), .spi_cs_n(spi_cs_n),
        .spi_sclk(spi_sclk), .spi_sdi(spi_sdi), .spi_sdo(spi_sdo),
        .spi_sdo_oe(spi_sdo_oe), .loop_a_powerdown_pin(pin),
        .loop_a_on(loop_a_on), .loop_b_on(loop_b_on),
        .loop_a_ref_choice(ref_choice), .reference_out_mode(ro_mode),
        .activity_detect_en(act_en), .reference_out_src(ro_src),
        .crystal_a_enable(xtal_en), .divider_en(div_en)
    );

    initial begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end

    task automatic tick(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask

    task automatic frame(input logic rd, input logic [6:0] a,
                         input logic [31:0] wd, output logic [31:0] r);
        logic [39:0] sh;
        sh = {rd, a, wd};
        r = 32'h0000_0000;
        spi_cs_n = 1'b0;
        tick(2);
        for (int i = 39; i >= 0; i--) begin
            spi_sdi = sh[i];
            tick(7);
            r = {r[30:0], spi_sdo};
            if (i == 0) begin
                oe_q = spi_sdo_oe;
            end
            spi_sclk = 1'b1;
            tick(7);
            spi_sclk = 1'b0;
        end
        tick(7);
        spi_cs_n = 1'b1;
        tick(8);
    endtask

    task automatic lp_case(input logic [15:0] w, input logic p,
        input logic ea, input logic eb, input logic ec, input logic [15:0] er);
        pin = p;
        frame(1'b0, spr_pkg::ADDR_LOOP_PWR, {16'h0000, w}, q);
        frame(1'b1, spr_pkg::ADDR_LOOP_PWR, 32'h0000_0000, q);
        `CHK("loop a power", ea, loop_a_on);
        `CHK("loop b power", eb, loop_b_on);
        `CHK("loop a reference", ec, ref_choice);
        `CHK("loop register", {16'h0000, er}, q);
        `CHK("data out enable", 1'b1, oe_q);
        `CHK("data out idle", 1'b0, spi_sdo_oe);
    endtask

    task automatic ro_case(input logic [31:0] w, input logic [31:0] er);
        frame(1'b0, spr_pkg::ADDR_REFERENCE_CLOCK_OUT, w, q);
        frame(1'b1, spr_pkg::ADDR_REFERENCE_CLOCK_OUT, 32'h0000_0000, q);
        `CHK("driver mode", er[31:30], ro_mode);
        `CHK("activity detect", er[28], act_en);
        `CHK("reference source", er[27], ro_src);
        `CHK("crystal a", er[26] | ~er[27], xtal_en);
        `CHK("dividers", er[19:16], div_en);
        `CHK("reference_clock_out register", er, q);
    endtask

    task automatic test_done;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask

    initial begin
        repeat (100000) @(posedge clock);
        n_fail++;
        test_done();
    end

    initial begin
        {sys_rst, spi_cs_n, spi_sclk, spi_sdi, pin} = 5'b11001;
        tick(8);
        sys_rst = 1'b0;
        tick(3);
        `CHK("reset loop a", 1'b1, loop_a_on);
        `CHK("reset loop b", 1'b0, loop_b_on);
        `CHK("reset choice", 1'b0, ref_choice);
        `CHK("reset mode", 2'h0, ro_mode);
        `CHK("reset activity", 1'b1, act_en);
        `CHK("reset source", 1'b0, ro_src);
        `CHK("reset crystal", 1'b1, xtal_en);
        `CHK("reset dividers", 4'h0, div_en);
        frame(1'b1, spr_pkg::ADDR_REFERENCE_CLOCK_OUT, 32'h0000_0000, q);
        `CHK("reset reference_clock_out", 32'h1000_0000, q);
        $display("test reset done");
        lp_case(16'h0002, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0000);
        lp_case(16'h0001, 1'b1, 1'b0, 1'b0, 1'b0, 16'h0001);
        lp_case(16'h0003, 1'b0, 1'b1, 1'b0, 1'b0, 16'h0003);
        lp_case(16'h0008, 1'b0, 1'b0, 1'b0, 1'b0, 16'h0008);
        lp_case(16'h000C, 1'b1, 1'b1, 1'b1, 1'b0, 16'h000E);
        lp_case(16'h0020, 1'b1, 1'b1, 1'b0, 1'b0, 16'h0022);
        lp_case(16'hFFF0, 1'b0, 1'b0, 1'b0, 1'b1, 16'h0030);
        $display("test loop register done");
        ro_case(32'hDC0F_0000, 32'hDC0F_0000);
        ro_case(32'h5800_0000, 32'h5800_0000);
        ro_case(32'h9C0A_0000, 32'h9C0A_0000);
        ro_case(32'h1005_0000, 32'h1005_0000);
        $display("test reference_clock_out register done");
        frame(1'b1, 7'h7F, 32'h0000_0000, q);
        `CHK("unmapped read", 32'h0000_0000, q);
        frame(1'b0, 7'h10, 32'hFFFF_FFFF, q);
        frame(1'b1, spr_pkg::ADDR_REFERENCE_CLOCK_OUT, 32'h0000_0000, q);
        `CHK("unmapped write", 32'h1005_0000, q);
        $display("test unmapped done");
        ro_case(32'h1800_0000, 32'h1800_0000);
        lp_case(16'h0000, 1'b1, 1'b1, 1'b0, 1'b0, 16'h0002);
        `CHK("crystal loop a", 1'b1, xtal_en);
        $display("test crystal demand done");
        test_done();
    end
endmodule // spr_top_tb_top
`undef CHK
`default_nettype wire
